//--- src/aci_pkg.sv
// Constants for the converter control and shared input port block
package aci_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int RES_W = 8;
  localparam int CH_W = 4;
  localparam int PINS = 8;
  localparam int CNT_W = 4;
  localparam int IDX_W = 3;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_PIN_LEVELS = 12'h003;
  localparam logic [ADDR_W-1:0] IDX_RESULT = 12'h008;
  localparam logic [ADDR_W-1:0] IDX_STATUS_CTL = 12'h009;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 12'h011;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 12'h012;
  localparam int ADDR_SHIFT = 2;

  // Status/control field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_RC_SEL = 6;
  localparam int BIT_ENABLE = 5;
  localparam int CH_LSB = 0;

  localparam logic [RES_W-1:0] CTL_RESET = 8'h00;
  localparam logic [RES_W-1:0] RESULT_RESET = 8'h00;
  localparam logic [RES_W-1:0] SAR_FIRST = 8'h80;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // Multiplexer codes
  localparam logic [CH_W-1:0] CH_LAST_PIN = 4'h7;
  localparam logic [CH_W-1:0] CH_REF_HIGH = 4'h8;
  localparam logic [CH_W-1:0] CH_REF_MID = 4'h9;

  // Sampling switch stays closed this many bus cycles
  localparam logic [CNT_W-1:0] SAMPLE_CYCLES = 4'hc;
  localparam logic [IDX_W-1:0] MSB_IDX = 3'h7;

  localparam int IRQ_W = 1;
  localparam int IRQ_DONE = 0;

  typedef enum logic [1:0] {AC_IDLE, AC_SAMPLE, AC_CONVERT} aci_state_type;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] idx);
    reg_addr = idx << ADDR_SHIFT;
  endfunction
endpackage

//--- src/aci_conv_if.sv
// Link between control logic and the successive-approximation engine
`timescale 1ns/1ps
interface aci_conv_if;
  import aci_pkg::*;
  logic run;
  logic start;
  logic step_en;
  logic cmp_high;
  logic sample_close;
  logic [RES_W-1:0] dac_code;
  logic done;
  logic [RES_W-1:0] result;
  modport ctl (output run, start, step_en, cmp_high,
               input sample_close, dac_code, done, result);
  modport eng (input run, start, step_en, cmp_high,
               output sample_close, dac_code, done, result);
endinterface

//--- src/aci_sar_engine.sv
// Sample window and bit-by-bit successive approximation sequencer
`timescale 1ns/1ps
module aci_sar_engine (
  input wire logic pclk,
  input wire logic presetn,
  aci_conv_if.eng conv
);
  import aci_pkg::*;

  aci_state_type state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [IDX_W-1:0] idx_r;
  logic [RES_W-1:0] sar_r;
  logic [RES_W-1:0] result_r;
  logic done_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= AC_IDLE;
      cnt_r <= '0;
      idx_r <= MSB_IDX;
      sar_r <= SAR_FIRST;
    end else if (!conv.run) begin
      state_r <= AC_IDLE;
      cnt_r <= '0;
    end else if (conv.start || state_r == AC_IDLE) begin
      state_r <= AC_SAMPLE;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        AC_SAMPLE: begin
          // Window counts bus cycles, whatever clocks the steps
          if (cnt_r == SAMPLE_CYCLES - 4'h1) begin
            state_r <= AC_CONVERT;
            idx_r <= MSB_IDX;
            sar_r <= SAR_FIRST;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        AC_CONVERT: begin
          if (conv.step_en) begin
            // Drop the trial bit if input lies below it
            if (!conv.cmp_high) begin
              sar_r[idx_r] <= 1'b0;
            end
            if (idx_r == '0) begin
              state_r <= AC_SAMPLE;
              cnt_r <= '0;
            end else begin
              idx_r <= idx_r - 3'h1;
              sar_r[idx_r - 3'h1] <= 1'b1;
            end
          end
        end
        default: state_r <= AC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      result_r <= RESULT_RESET;
    end else begin
      done_r <= 1'b0;
      if (conv.run && !conv.start && state_r == AC_CONVERT && conv.step_en
          && idx_r == '0) begin
        done_r <= 1'b1;
        result_r <= {sar_r[RES_W-1:1], conv.cmp_high};
      end
    end
  end

  assign conv.sample_close = (state_r == AC_SAMPLE);
  assign conv.dac_code = sar_r;
  assign conv.done = done_r;
  assign conv.result = result_r;

  // Closed-switch cycles counted apart from the sequencer's own counter
  logic [CNT_W-1:0] win_len_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_len_r <= '0;
    end else if (!conv.sample_close || conv.start || !conv.run) begin
      win_len_r <= '0;
    end else begin
      win_len_r <= win_len_r + 4'h1;
    end
  end

  sequence s_window_full;
    conv.sample_close && win_len_r == SAMPLE_CYCLES - 4'h1 && conv.run && !conv.start;
  endsequence

  AST_SAMPLE_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
    s_window_full |=> !conv.sample_close)
    else $error("sampling switch not opened after 12 cycles");

  AST_SAMPLE_MIN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(conv.sample_close) && $past(conv.run) |-> $past(win_len_r) == SAMPLE_CYCLES - 4'h1)
    else $error("sampling switch opened before 12 cycles");

  AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    conv.done && conv.run |-> conv.sample_close)
    else $error("no new conversion after completion");

  AST_BIT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == AC_CONVERT && conv.step_en && idx_r != '0 && conv.run && !conv.start
    |=> idx_r == $past(idx_r) - 3'h1)
    else $error("bit index did not step down by one");
endmodule

//--- src/aci_adc_ctl.sv
// Converter control registers, shared input port and interrupt logic
`timescale 1ns/1ps
module aci_adc_ctl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [aci_pkg::ADDR_W-1:0] paddr,
  input wire logic [aci_pkg::DATA_W-1:0] pwdata,
  output logic [aci_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [aci_pkg::PINS-1:0] shared_input_pins,
  input wire logic stop_mode,
  input wire logic rc_clk_tick,
  input wire logic cmp_high,
  output logic rc_osc_enable,
  output logic converter_power,
  output logic sample_switch,
  output logic [aci_pkg::RES_W-1:0] dac_code,
  output logic [aci_pkg::PINS-1:0] pin_select,
  output logic ref_high_select,
  output logic ref_mid_select,
  output logic ref_low_select,
  output logic irq
);
  import aci_pkg::*;

  aci_conv_if conv ();

  logic done_flag_r;
  logic rc_clock_select_r;
  logic converter_enable_r;
  logic [CH_W-1:0] channel_select_r;
  logic [RES_W-1:0] conversion_result_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_enable_r;
  logic [DATA_W-1:0] prdata_r;
  logic pslverr_r;

  logic setup;
  logic access;
  logic wr_ctl;
  logic rd_result;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic mapped;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] idx);
    hit = (a == reg_addr(idx));
  endfunction

  // Bus decode; every access finishes in its first access cycle
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_ctl = access && pwrite && hit(paddr, IDX_STATUS_CTL);
  assign rd_result = access && !pwrite && hit(paddr, IDX_RESULT);
  assign wr_irq_en = access && pwrite && hit(paddr, IDX_IRQ_ENABLE);
  assign wr_irq_clr = access && pwrite && hit(paddr, IDX_IRQ_CLEAR);
  assign mapped = hit(paddr, IDX_PIN_LEVELS) || hit(paddr, IDX_RESULT)
               || hit(paddr, IDX_STATUS_CTL) || hit(paddr, IDX_IRQ_STATUS)
               || hit(paddr, IDX_IRQ_ENABLE) || hit(paddr, IDX_IRQ_CLEAR);

  // Control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_clock_select_r <= CTL_RESET[BIT_RC_SEL];
      converter_enable_r <= CTL_RESET[BIT_ENABLE];
      channel_select_r <= CTL_RESET[CH_LSB +: CH_W];
    end else if (wr_ctl) begin
      rc_clock_select_r <= pwdata[BIT_RC_SEL];
      converter_enable_r <= pwdata[BIT_ENABLE];
      channel_select_r <= pwdata[CH_LSB +: CH_W];
    end
  end

  // Done flag: completion outranks a same-cycle result read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_r <= CTL_RESET[BIT_DONE];
    end else if (conv.done && !wr_ctl) begin
      done_flag_r <= 1'b1;
    end else if (rd_result || wr_ctl) begin
      done_flag_r <= 1'b0;
    end
  end

  // Result only changes on completion; bus writes cannot touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_r <= RESULT_RESET;
    end else if (conv.done && !wr_ctl) begin
      conversion_result_r <= conv.result;
    end
  end

  // Interrupt status: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (i == IRQ_DONE && conv.done && !wr_ctl) begin
          irq_status_r[i] <= 1'b1;
        end else if (wr_irq_clr && pwdata[i]) begin
          irq_status_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_r <= '0;
    end else if (wr_irq_en) begin
      irq_enable_r <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_r & irq_enable_r);

  // Read data captured in the setup cycle; pins sampled whatever the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= ZERO_WORD;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= ZERO_WORD;
      pslverr_r <= !mapped;
      if (!pwrite) begin
        if (hit(paddr, IDX_PIN_LEVELS)) begin
          prdata_r[PINS-1:0] <= shared_input_pins;
        end else if (hit(paddr, IDX_RESULT)) begin
          prdata_r[RES_W-1:0] <= conversion_result_r;
        end else if (hit(paddr, IDX_STATUS_CTL)) begin
          prdata_r[BIT_DONE] <= done_flag_r;
          prdata_r[BIT_RC_SEL] <= rc_clock_select_r;
          prdata_r[BIT_ENABLE] <= converter_enable_r;
          prdata_r[CH_LSB +: CH_W] <= channel_select_r;
        end else if (hit(paddr, IDX_IRQ_STATUS)) begin
          prdata_r[IRQ_W-1:0] <= irq_status_r;
        end else if (hit(paddr, IDX_IRQ_ENABLE)) begin
          prdata_r[IRQ_W-1:0] <= irq_enable_r;
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access && pslverr_r;

  // Power and clocking; no wait input exists, so WAIT cannot disturb it
  assign rc_osc_enable = rc_clock_select_r && !stop_mode;
  assign converter_power = converter_enable_r && !stop_mode;
  assign conv.run = converter_power;
  assign conv.start = wr_ctl;
  // With the RC clock selected its ticks pace the steps, else every bus cycle steps; a slow bus would otherwise lose accuracy
  assign conv.step_en = rc_clock_select_r ? rc_clk_tick : 1'b1;
  assign conv.cmp_high = cmp_high;

  aci_sar_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .conv(conv)
  );

  assign sample_switch = conv.sample_close;
  assign dac_code = conv.dac_code;

  // Multiplexer decode
  always_comb begin
    pin_select = '0;
    ref_high_select = 1'b0;
    ref_mid_select = 1'b0;
    ref_low_select = 1'b0;
    if (channel_select_r <= CH_LAST_PIN) begin
      pin_select[channel_select_r[IDX_W-1:0]] = 1'b1;
    end else if (channel_select_r == CH_REF_HIGH) begin
      ref_high_select = 1'b1;
    end else if (channel_select_r == CH_REF_MID) begin
      ref_mid_select = 1'b1;
    end else begin
      ref_low_select = 1'b1;
    end
  end

  sequence s_pin_read;
    setup && !pwrite && hit(paddr, IDX_PIN_LEVELS);
  endsequence

  AST_PIN_READ: assert property (@(posedge pclk) disable iff (!presetn)
    s_pin_read |=> prdata[PINS-1:0] == $past(shared_input_pins))
    else $error("pin levels not returned");

  AST_DONE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    conv.done && !wr_ctl |=> done_flag_r && conversion_result_r == $past(conv.result))
    else $error("result and flag not loaded together");

  AST_CLEAR_ON_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl |=> !done_flag_r ##1 (done_flag_r == $past(conv.done)))
    else $error("flag not cleared by control write");

  AST_CLEAR_ON_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_result && !conv.done && !wr_ctl |=> !done_flag_r)
    else $error("flag not cleared by result read");

  AST_RC_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    rc_clock_select_r && !converter_enable_r && !stop_mode
    |-> rc_osc_enable && !converter_power ##1 !sample_switch)
    else $error("oscillator-only mode wrong");

  AST_STOP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode [*2] |-> !rc_osc_enable && !sample_switch && !conv.done)
    else $error("converter active in stop");

  AST_RESTART_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && pwdata[BIT_ENABLE] && !stop_mode ##1 !stop_mode
    |-> !done_flag_r ##1 sample_switch)
    else $error("control write did not restart sampling");

  AST_MUX_MID: assert property (@(posedge pclk) disable iff (!presetn)
    channel_select_r == CH_REF_MID |-> ref_mid_select && pin_select == '0)
    else $error("midpoint not selected");
endmodule

//--- dv/aci_analog_src.sv
// Analog sources behind the shared pins, with sample-and-hold and comparator
`timescale 1ns/1ps
module aci_analog_src (
  input wire logic pclk,
  input wire logic [63:0] pin_volts,
  input wire logic sample_switch,
  input wire logic [7:0] dac_code,
  input wire logic [7:0] pin_select,
  input wire logic ref_high_select,
  input wire logic ref_mid_select,
  input wire logic ref_low_select,
  output logic cmp_high
);
  logic [7:0] held_r = 8'h00;
  logic [7:0] sel_v;

  always_comb begin
    // No source selected: show a level unlike the held one
    sel_v = ~held_r;
    for (int i = 0; i < 8; i++) begin
      if (pin_select[i]) sel_v = pin_volts[8*i +: 8];
    end
    if (ref_high_select) sel_v = 8'hff;
    if (ref_mid_select) sel_v = 8'h80;
    if (ref_low_select) sel_v = 8'h00;
  end

  // Capacitor follows the source only while the switch is closed
  always_ff @(posedge pclk) begin
    if (sample_switch) held_r <= sel_v;
  end

  assign cmp_high = held_r >= dac_code;
endmodule

//--- dv/aci_adc_ctl_tb.sv
// Register-level bench for the converter control block
`timescale 1ns/1ps
module aci_adc_ctl_tb;
  import aci_pkg::*;
  localparam logic [63:0] VOLTS = 64'h0fe1_c3a5_5a3c_1e87;
  localparam logic [ADDR_W-1:0] A_PIN = 12'h00c;
  localparam logic [ADDR_W-1:0] A_RES = 12'h020;
  localparam logic [ADDR_W-1:0] A_CTL = 12'h024;
  localparam logic [ADDR_W-1:0] A_IST = 12'h040;
  localparam logic [ADDR_W-1:0] A_IEN = 12'h044;
  localparam logic [ADDR_W-1:0] A_ICL = 12'h048;
  localparam logic [ADDR_W-1:0] A_BAD = 12'h100;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [PINS-1:0] shared_input_pins = 8'h00;
  logic stop_mode = 1'b0;
  logic rc_clk_tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, cmp_high, rc_osc_enable, converter_power, sample_switch, irq;
  logic [RES_W-1:0] dac_code;
  logic [PINS-1:0] pin_select;
  logic ref_high_select, ref_mid_select, ref_low_select;
  int err_total = 0;
  int total_checks = 0;
  int run_len = 0;
  int last_run = 0;

  aci_adc_ctl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .shared_input_pins, .stop_mode, .rc_clk_tick, .cmp_high,
    .rc_osc_enable, .converter_power, .sample_switch, .dac_code, .pin_select,
    .ref_high_select, .ref_mid_select, .ref_low_select, .irq);
  aci_analog_src i_src (.pclk, .pin_volts(VOLTS), .sample_switch, .dac_code, .pin_select,
    .ref_high_select, .ref_mid_select, .ref_low_select, .cmp_high);

  initial begin
    forever #4 pclk = ~pclk;
  end

  // RC oscillator ticks at a quarter of the bus rate
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    rc_clk_tick <= (tick_cnt == 2'h0);
  end

  always @(posedge pclk) begin
    if (sample_switch === 1'b1) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) last_run <= run_len;
      run_len <= 0;
    end
  end

  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Starts one edge later so no signal is driven twice in a time step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wait_done();
    logic [DATA_W-1:0] q;
    int n;
    q = 32'h0;
    n = 0;
    while (q[BIT_DONE] !== 1'b1 && n < 100) begin
      rd(A_CTL, q);
      n++;
    end
    chk(32'(q[BIT_DONE]), 32'h1);
  endtask

  function automatic logic [7:0] exp_lvl(input int c);
    if (c < 8) exp_lvl = VOLTS[8*c +: 8];
    else if (c == 8) exp_lvl = 8'hff;
    else if (c == 9) exp_lvl = 8'h80;
    else exp_lvl = 8'h00;
  endfunction

  initial begin
    #100000;
    err_total++;
    give_verdict();
  end

  initial begin
    logic [DATA_W-1:0] q;
    logic e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, q);
    chk(q, 32'h0);
    rd(A_RES, q);
    chk(q, 32'h0);
    chk(32'({rc_osc_enable, converter_power}), 32'h0);
    shared_input_pins <= 8'ha5;
    rd(A_PIN, q);
    chk(q, 32'ha5);
    apb(1'b0, A_BAD, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(A_RES, 32'h55);
    rd(A_RES, q);
    chk(q, 32'h0);
    wr(A_IEN, 32'h1);
    wr(A_CTL, 32'h23);
    rd(A_CTL, q);
    chk(q, 32'h23);
    wait_done();
    chk(32'(last_run), 32'd12);
    rd(A_RES, q);
    chk(q, 32'(exp_lvl(3)));
    rd(A_CTL, q);
    chk(q, 32'h23);
    shared_input_pins <= 8'h3c;
    rd(A_PIN, q);
    chk(q, 32'h3c);
    @(negedge pclk);
    chk(32'({irq, converter_power, rc_osc_enable}), 32'h6);
    wr(A_CTL, 32'h0);
    wr(A_ICL, 32'h1);
    rd(A_IST, q);
    chk(q, 32'h0);
    @(negedge pclk);
    chk(32'({irq, converter_power}), 32'h0);
    wr(A_IEN, 32'h0);
    wr(A_CTL, 32'h20);
    wait_done();
    rd(A_IST, q);
    chk({q[30:0], irq}, 32'h2);
    for (int c = 0; c < 16; c++) begin
      wr(A_CTL, 32'h20 | c);
      @(negedge pclk);
      chk(32'(pin_select), (c < 8) ? (32'h1 << c) : 32'h0);
      chk(32'({ref_high_select, ref_mid_select, ref_low_select}),
          (c == 8) ? 32'h4 : (c == 9) ? 32'h2 : (c > 9) ? 32'h1 : 32'h0);
      wait_done();
      rd(A_RES, q);
      chk(q, 32'(exp_lvl(c)));
    end
    wr(A_CTL, 32'h40);
    @(negedge pclk);
    chk(32'({rc_osc_enable, converter_power}), 32'h2);
    wr(A_CTL, 32'h65);
    @(negedge pclk);
    chk(32'({rc_osc_enable, converter_power}), 32'h3);
    wait_done();
    rd(A_RES, q);
    chk(q, 32'(exp_lvl(5)));
    @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (80) @(posedge pclk);
    @(negedge pclk);
    chk(32'({rc_osc_enable, converter_power, sample_switch}), 32'h0);
    rd(A_CTL, q);
    chk(q, 32'h65);
    @(posedge pclk);
    stop_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({irq, sample_switch, pin_select}), 32'h1);
    presetn <= 1'b1;
    rd(A_CTL, q);
    chk(q, 32'h0);
    rd(A_RES, q);
    chk(q, 32'h0);
    give_verdict();
  end
endmodule
